// *** logic/phase_acc_pkg.sv ***
`default_nettype none
package phase_acc_pkg;
  // Bus geometry.
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  // Register byte addresses.
  localparam logic [5:0] CTRL_OFS = 6'h00;
  localparam logic [5:0] CLKCFG_OFS = 6'h04;
  localparam logic [5:0] ACC_L_OFS = 6'h08;
  localparam logic [5:0] ACC_H_OFS = 6'h0C;
  localparam logic [5:0] ACC_U_OFS = 6'h10;
  localparam logic [5:0] INC_L_OFS = 6'h14;
  localparam logic [5:0] INC_H_OFS = 6'h18;
  localparam logic [5:0] INC_U_OFS = 6'h1C;
  localparam logic [5:0] IRQ_STAT_OFS = 6'h20;
  localparam logic [5:0] IRQ_CLR_OFS = 6'h24;
  localparam logic [5:0] IRQ_EN_OFS = 6'h28;
  // Control register field positions.
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_OUT_BIT = 5;
  localparam int CTRL_POL_BIT = 4;
  localparam int CTRL_PFM_BIT = 0;
  // Clock configuration field positions.
  localparam int PWS_LSB = 5;
  localparam int CKS_LSB = 0;
  // Accumulator and increment geometry.
  localparam int ACC_W = 20;
  localparam int UPPER_W = 4;
  localparam int NUM_SRC = 14;
  // Clock select codes.
  localparam logic [3:0] CKS_SYSCLK = 4'h0;
  localparam logic [3:0] CKS_RESERVED = 4'hF;
  // Input-clock edges from a low-byte write to the buffer load.
  localparam logic [1:0] INC_LOAD_EDGES = 2'h2;
  // Values after reset.
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [ACC_W-1:0] ACC_RST = 20'h00000;
  // Response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : phase_acc_pkg
`default_nettype wire

// *** logic/phase_accumulator_oscillator.sv ***
// Overview of operation
// - The phase sum lives in a 20-bit accumulator.
// - Each selected input-clock rising edge adds the buffered increment.
// - The carry out of that addition is the raw overflow output.
// - Overflow rate is input rate times increment over two to twenty.
// - Increment is held in low, high and upper byte registers.
// - Software reads and writes the accumulator through three bytes.
// - Increment bytes are read/write; the adder uses a buffered copy.
// - Enabled: low-byte write loads all bytes on second edge after.
// - Disabled: any increment byte write loads the buffer at once.
// - The increment buffer has no address of its own.
// - A clock-select field picks the adder clock among several sources.
// - Overflow jitter is at most one input period, none without remainder.
// - Square-wave mode toggles the output on every overflow.
// - Pulse mode drives active for 1 to 128 periods after overflow.
// - The invert bit flips the final output; cleared means active high.
// - Each overflow sets a sticky flag until software clears it.
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module phase_accumulator_oscillator
  import phase_acc_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [NUM_SRC-1:0] clk_src_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic raw_overflow_carry_out,
  output logic osc_out,
  output logic irq_out
);

  logic aw_hold_r;
  logic w_hold_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [7:0] w_byte_r;
  logic w_lane_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [DATA_W-1:0] rdata_r;
  logic [1:0] rresp_r;
  logic do_wr;
  logic wr_hit;
  logic do_rd;
  logic [7:0] rd_val;
  logic rd_hit;
  logic en_r;
  logic pol_r;
  logic pfm_r;
  logic [2:0] pws_r;
  logic [3:0] cks_r;
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_nxt;
  logic carry_nxt;
  logic [7:0] inc_l_r;
  logic [7:0] inc_h_r;
  logic [UPPER_W-1:0] inc_u_r;
  logic [ACC_W-1:0] inc_buf_r;
  logic [1:0] load_wait_r;
  logic load_now_r;
  logic src_lvl;
  logic src_prev_r;
  logic tick;
  logic ovf;
  logic ovf_r;
  logic fdc_lvl_r;
  logic pf_arm_r;
  logic pf_lvl_r;
  logic [6:0] pw_cnt_r;
  logic [6:0] pw_len;
  logic out_r;
  logic stat_r;
  logic irq_en_r;
  logic wr_ctrl;
  logic wr_clk;
  logic wr_acc_l;
  logic wr_acc_h;
  logic wr_acc_u;
  logic wr_inc_l;
  logic wr_inc_h;
  logic wr_inc_u;
  logic wr_clr;
  logic wr_ien;

  // Address and data are taken separately; the write fires once both are held.
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign do_wr = aw_hold_r && w_hold_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // Holding registers for the write address channel.
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end
    else if (do_wr)
    begin
      aw_hold_r <= 1'b0;
    end
  end

  // Holding registers for the write data channel; only lane 0 carries data.
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      w_hold_r <= 1'b0;
      w_byte_r <= BYTE_RST;
      w_lane_r <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold_r <= 1'b1;
      w_byte_r <= s_axi_wdata[7:0];
      w_lane_r <= s_axi_wstrb[0];
    end
    else if (do_wr)
    begin
      w_hold_r <= 1'b0;
    end
  end

  // Per-register write strobes, gated by byte lane 0.
  always_comb
  begin
    wr_ctrl = 1'b0;
    wr_clk = 1'b0;
    wr_acc_l = 1'b0;
    wr_acc_h = 1'b0;
    wr_acc_u = 1'b0;
    wr_inc_l = 1'b0;
    wr_inc_h = 1'b0;
    wr_inc_u = 1'b0;
    wr_clr = 1'b0;
    wr_ien = 1'b0;
    wr_hit = 1'b1;
    case (aw_addr_r)
      CTRL_OFS: wr_ctrl = do_wr && w_lane_r;
      CLKCFG_OFS: wr_clk = do_wr && w_lane_r;
      ACC_L_OFS: wr_acc_l = do_wr && w_lane_r;
      ACC_H_OFS: wr_acc_h = do_wr && w_lane_r;
      ACC_U_OFS: wr_acc_u = do_wr && w_lane_r;
      INC_L_OFS: wr_inc_l = do_wr && w_lane_r;
      INC_H_OFS: wr_inc_h = do_wr && w_lane_r;
      INC_U_OFS: wr_inc_u = do_wr && w_lane_r;
      IRQ_STAT_OFS: wr_hit = 1'b1;
      IRQ_CLR_OFS: wr_clr = do_wr && w_lane_r;
      IRQ_EN_OFS: wr_ien = do_wr && w_lane_r;
      default: wr_hit = 1'b0;
    endcase
  end

  // Write response; unmapped addresses answer with a slave error.
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_r <= 1'b0;
    end
  end

  // Read channel: one read at a time, answered on the next edge.
  assign s_axi_arready = !rvalid_r;
  assign do_rd = s_axi_arvalid && !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // Read mux; the increment buffer is deliberately not decoded.
  always_comb
  begin
    rd_val = BYTE_RST;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      CTRL_OFS: rd_val = {en_r, 1'b0, out_r, pol_r, 3'h0, pfm_r};
      CLKCFG_OFS: rd_val = {pws_r, 1'b0, cks_r};
      ACC_L_OFS: rd_val = acc_r[7:0];
      ACC_H_OFS: rd_val = acc_r[15:8];
      ACC_U_OFS: rd_val = {4'h0, acc_r[19:16]};
      INC_L_OFS: rd_val = inc_l_r;
      INC_H_OFS: rd_val = inc_h_r;
      INC_U_OFS: rd_val = {4'h0, inc_u_r};
      IRQ_STAT_OFS: rd_val = {7'h00, stat_r};
      IRQ_CLR_OFS: rd_val = BYTE_RST;
      IRQ_EN_OFS: rd_val = {7'h00, irq_en_r};
      default: rd_hit = 1'b0;
    endcase
  end

  // Read data register; upper bits read as zero.
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end
    else if (do_rd)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h000000, rd_val};
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      rvalid_r <= 1'b0;
    end
  end

  // Control and clock configuration registers.
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      en_r <= 1'b0;
      pol_r <= 1'b0;
      pfm_r <= 1'b0;
      pws_r <= 3'h0;
      cks_r <= CKS_SYSCLK;
    end
    else
    begin
      if (wr_ctrl)
      begin
        en_r <= w_byte_r[CTRL_EN_BIT];
        pol_r <= w_byte_r[CTRL_POL_BIT];
        pfm_r <= w_byte_r[CTRL_PFM_BIT];
      end
      if (wr_clk)
      begin
        pws_r <= w_byte_r[PWS_LSB +: 3];
        cks_r <= w_byte_r[CKS_LSB +: 4];
      end
    end
  end

  // Source selection; code 0 ticks every cycle, the reserved code never.
  always_comb
  begin
    src_lvl = 1'b0;
    if (cks_r != CKS_SYSCLK && cks_r != CKS_RESERVED)
    begin
      src_lvl = clk_src_in[cks_r - 4'h1];
    end
  end

  // Remembers the last level of the selected source.
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      src_prev_r <= 1'b0;
    end
    else
    begin
      src_prev_r <= src_lvl;
    end
  end

  // One tick per rising edge of the selected input clock.
  assign tick = (cks_r == CKS_SYSCLK) || (src_lvl && !src_prev_r);

  // Full adder; the carry above bit 19 is the raw overflow.
  assign {carry_nxt, acc_nxt} = {1'b0, acc_r} + {1'b0, inc_buf_r};
  // A software accumulator write displaces the add, so it reports no overflow either.
  assign ovf = en_r && tick && carry_nxt && !(wr_acc_l || wr_acc_h || wr_acc_u);

  // Accumulator: software byte writes take priority over an addition.
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      acc_r <= ACC_RST;
    end
    else if (wr_acc_l || wr_acc_h || wr_acc_u)
    begin
      if (wr_acc_l)
      begin
        acc_r[7:0] <= w_byte_r;
      end
      if (wr_acc_h)
      begin
        acc_r[15:8] <= w_byte_r;
      end
      if (wr_acc_u)
      begin
        acc_r[19:16] <= w_byte_r[UPPER_W-1:0];
      end
    end
    else if (en_r && tick)
    begin
      acc_r <= acc_nxt;
    end
  end

  // Increment byte registers seen by software.
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      inc_l_r <= BYTE_RST;
      inc_h_r <= BYTE_RST;
      inc_u_r <= '0;
    end
    else
    begin
      if (wr_inc_l)
      begin
        inc_l_r <= w_byte_r;
      end
      if (wr_inc_h)
      begin
        inc_h_r <= w_byte_r;
      end
      if (wr_inc_u)
      begin
        inc_u_r <= w_byte_r[UPPER_W-1:0];
      end
    end
  end

  // Load scheduling: countdown of input edges when enabled, next cycle when not.
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      load_wait_r <= 2'h0;
      load_now_r <= 1'b0;
    end
    else
    begin
      load_now_r <= !en_r && (wr_inc_l || wr_inc_h || wr_inc_u);
      if (en_r && wr_inc_l)
      begin
        load_wait_r <= INC_LOAD_EDGES;
      end
      else if (!en_r)
      begin
        load_wait_r <= 2'h0;
      end
      else if (tick && load_wait_r != 2'h0)
      begin
        load_wait_r <= load_wait_r - 2'h1;
      end
    end
  end

  // Hidden double buffer feeding the adder; all three bytes load together.
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      inc_buf_r <= ACC_RST;
    end
    else if (load_now_r || (tick && load_wait_r == 2'h1))
    begin
      inc_buf_r <= {inc_u_r, inc_h_r, inc_l_r};
    end
  end

  // Pulse length minus one: 2 to the power of the width field, less one.
  assign pw_len = 7'((8'h01 << pws_r) - 8'h01);

  // Square-wave stage toggles on each overflow.
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      fdc_lvl_r <= 1'b0;
    end
    else if (ovf)
    begin
      fdc_lvl_r <= !fdc_lvl_r;
    end
  end

  // Pulse stage: active from the tick after overflow for the chosen length.
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      pf_arm_r <= 1'b0;
      pf_lvl_r <= 1'b0;
      pw_cnt_r <= 7'h00;
    end
    else if (tick && pf_arm_r)
    begin
      pf_arm_r <= ovf;
      pf_lvl_r <= 1'b1;
      pw_cnt_r <= pw_len;
    end
    else
    begin
      if (ovf)
      begin
        pf_arm_r <= 1'b1;
      end
      if (tick && pf_lvl_r)
      begin
        if (pw_cnt_r == 7'h00)
        begin
          pf_lvl_r <= 1'b0;
        end
        else
        begin
          pw_cnt_r <= pw_cnt_r - 7'h01;
        end
      end
    end
  end

  // Final stage: mode select then polarity, registered.
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      out_r <= 1'b0;
      ovf_r <= 1'b0;
    end
    else
    begin
      out_r <= (pfm_r ? pf_lvl_r : fdc_lvl_r) ^ pol_r;
      ovf_r <= ovf;
    end
  end

  assign osc_out = out_r;
  assign raw_overflow_carry_out = ovf_r;

  // Sticky overflow flag; a new overflow wins over a clear in the same cycle.
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      stat_r <= 1'b0;
      irq_en_r <= 1'b0;
    end
    else
    begin
      if (ovf)
      begin
        stat_r <= 1'b1;
      end
      else if (wr_clr && w_byte_r[0])
      begin
        stat_r <= 1'b0;
      end
      if (wr_ien)
      begin
        irq_en_r <= w_byte_r[0];
      end
    end
  end

  // Level interrupt while an enabled flag is set.
  assign irq_out = stat_r && irq_en_r;

endmodule : phase_accumulator_oscillator
`default_nettype wire

// *** dv/phase_accumulator_oscillator_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module phase_osc_props
  import phase_acc_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic raw_overflow_carry_out,
  input wire logic irq_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // Both write channels taken at one edge.
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Read address taken.
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Bus answers, their holding and the refusals while busy.
  wr_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("Write got no response.");
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("Read got no response.");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped early.");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped early.");
  write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write taken while response pending.");
  read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read taken while data pending.");
  unmapped_err_a: assert property (wr_take ##0 (s_axi_awaddr == 6'h2C) |-> ##2 s_axi_bresp == RESP_SLVERR)
    else $error("Unmapped write not refused.");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("Upper read bits not zero.");
  // The interrupt only rises on an overflow or a register write, and only falls on a write or reset.
  irq_rise_a: assert property ($rose(irq_out) |-> raw_overflow_carry_out || s_axi_bvalid)
    else $error("Interrupt rose without cause.");
  irq_sticky_a: assert property ($fell(irq_out) |-> s_axi_bvalid || $past(reset_in))
    else $error("Interrupt fell without a write.");
endmodule : phase_osc_props
bind phase_accumulator_oscillator phase_osc_props u_props (.sys_clk_in, .reset_in,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .raw_overflow_carry_out, .irq_out);
`default_nettype wire

// *** dv/phase_accumulator_oscillator_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module phase_accumulator_oscillator_tb
  import phase_acc_pkg::*;
;
  typedef struct {logic [5:0] a; logic [7:0] v; logic [1:0] e; logic [7:0] q;} row_t;
  // Writes made while disabled: address, data, response, read-back.
  row_t rows [10] = '{'{INC_L_OFS, 8'hA5, RESP_OKAY, 8'hA5}, '{INC_H_OFS, 8'h5A, RESP_OKAY, 8'h5A},
    '{INC_U_OFS, 8'h07, RESP_OKAY, 8'h07}, '{ACC_L_OFS, 8'h12, RESP_OKAY, 8'h12},
    '{ACC_H_OFS, 8'h34, RESP_OKAY, 8'h34}, '{ACC_U_OFS, 8'h05, RESP_OKAY, 8'h05},
    '{IRQ_EN_OFS, 8'h01, RESP_OKAY, 8'h01}, '{CLKCFG_OFS, 8'hF0, RESP_OKAY, 8'hE0},
    '{CTRL_OFS, 8'h11, RESP_OKAY, 8'h31}, '{6'h2C, 8'h3C, RESP_SLVERR, 8'h00}};
  // Pulse setups: clock config, control, cycles high out of 64.
  logic [7:0] pf [4][3] = '{'{8'h00, 8'h81, 8'h04}, '{8'h40, 8'h81, 8'h10},
    '{8'h40, 8'h91, 8'h30}, '{8'hE0, 8'h81, 8'h40}};
  // Clock-select codes and overflows expected in 80 cycles.
  logic [7:0] cs [4][2] = '{'{8'h01, 8'h0A}, '{8'h05, 8'h05}, '{8'h0E, 8'h0A}, '{8'h0F, 8'h00}};
  logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, raw, osc, irq, po;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, d2;
  logic [1:0] bresp, rresp, r;
  logic [13:0] src = 14'h0000;
  logic [3:0] div = 4'h0;
  logic [3:0] strb = 4'hF;
  int errors, total_checks, rc, hc, tc, i;
  phase_accumulator_oscillator DUT (.sys_clk_in(clk), .reset_in(rst), .clk_src_in(src),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .raw_overflow_carry_out(raw), .osc_out(osc), .irq_out(irq));
  // System clock.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Sources 1 and 14 rise every fourth cycle, the others every eighth.
  always @(posedge clk)
  begin
    div <= div + 4'h1;
    src <= {div[1], {12{div[2]}}, div[1]};
  end
  // Compares a seen value with the expected one.
  task chk(input logic [31:0] s, input logic [31:0] e, input string n);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %s exp %h saw %h", n, e, s);
    end
  endtask : chk
  // One bus write; bready rises only once the response is seen, so its hold is exercised.
  task wr(input logic [5:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic ta, tw, got, seen;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    got = 1'b0;
    while (!got)
    begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      seen = bvalid;
      got = bvalid & bready;
      resp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (seen && !got) bready <= 1'b1;
    end
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr
  // One bus read; the response code is left in r.
  task rd(input logic [5:0] a, output logic [31:0] v);
    logic ta, got, seen;
    araddr <= a;
    arvalid <= 1'b1;
    got = 1'b0;
    while (!got)
    begin
      @(negedge clk);
      ta = arvalid & arready;
      seen = rvalid;
      got = rvalid & rready;
      v = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (seen && !got) rready <= 1'b1;
    end
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd
  // Byte write that must be accepted.
  task w(input logic [5:0] a, input logic [7:0] v);
    wr(a, {24'h000000, v}, r);
    chk(r, RESP_OKAY, "bresp");
  endtask : w
  // Increment written upper and high first, low last.
  task setinc(input logic [19:0] v);
    w(INC_U_OFS, {4'h0, v[19:16]});
    w(INC_H_OFS, v[15:8]);
    w(INC_L_OFS, v[7:0]);
  endtask : setinc
  // Counts overflow pulses, output high cycles and output changes.
  task run(input int n);
    rc = 0;
    hc = 0;
    tc = 0;
    @(negedge clk);
    po = osc;
    repeat (n)
    begin
      @(negedge clk);
      rc += (raw === 1'b1);
      hc += (osc === 1'b1);
      tc += (osc !== po);
      po = osc;
    end
    @(posedge clk);
  endtask : run
  // Prints the verdict and ends the run.
  task stop_test;
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  // Cuts a hang short.
  initial
  begin
    #60000;
    errors++;
    stop_test;
  end
  // Main sequence.
  initial
  begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = '0;
    rst = 1'b1;
    {awaddr, araddr, wdata, errors, total_checks} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 12; i++)
      if (i != 9)
      begin
        rd(6'(i * 4), d);
        chk(d, 32'h0, "reset value");
        chk(r, (i == 11) ? RESP_SLVERR : RESP_OKAY, "rresp");
      end
    foreach (rows[k])
    begin
      wr(rows[k].a, {24'h000000, rows[k].v}, r);
      chk(r, rows[k].e, "resp");
      rd(rows[k].a, d);
      chk(d, rows[k].q, "readback");
      chk(r, rows[k].e, "read resp");
    end
    setinc(20'h80000);
    w(CTRL_OFS, 8'h80);
    run(40);
    chk(rc, 32'h14, "overflows");
    chk(tc, 32'h14, "toggles");
    chk(irq, 1'b1, "irq set");
    w(INC_U_OFS, 8'h03);
    run(40);
    chk(rc, 32'h14, "no early load");
    w(INC_L_OFS, 8'h00);
    run(8);
    run(64);
    chk(rc, 32'h0C, "remainder rate");
    w(CTRL_OFS, 8'h00);
    rd(ACC_U_OFS, d);
    run(10);
    rd(ACC_U_OFS, d2);
    chk(d2, d, "acc held");
    rd(IRQ_STAT_OFS, d);
    chk(d, 32'h1, "status");
    w(IRQ_EN_OFS, 8'h00);
    chk(irq, 1'b0, "irq masked");
    w(IRQ_EN_OFS, 8'h01);
    chk(irq, 1'b1, "irq unmasked");
    w(IRQ_CLR_OFS, 8'h01);
    chk(irq, 1'b0, "irq cleared");
    setinc(20'h10000);
    for (i = 0; i < 4; i++)
    begin
      w(CLKCFG_OFS, pf[i][0]);
      w(CTRL_OFS, pf[i][1]);
      run(20);
      run(64);
      chk(hc, pf[i][2], "pulse high");
    end
    w(CTRL_OFS, 8'h80);
    w(CLKCFG_OFS, 8'h00);
    setinc(20'h80000);
    for (i = 0; i < 4; i++)
    begin
      w(CLKCFG_OFS, cs[i][0]);
      run(8);
      run(80);
      chk(rc, cs[i][1], "source rate");
    end
    w(CLKCFG_OFS, 8'h00);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(CTRL_OFS, d);
    chk(d, 32'h0, "ctrl after reset");
    run(20);
    chk(rc, 32'h0, "idle after reset");
    strb <= 4'hE;
    w(ACC_L_OFS, 8'h55);
    strb <= 4'hF;
    rd(ACC_L_OFS, d);
    chk(d, 32'h0, "strobe off");
    stop_test;
  end
endmodule : phase_accumulator_oscillator_tb
`default_nettype wire
